//--- design/mqf_cfg.svh
/*
  Constants of the multi-queue flag block: widths, depths, field positions, reset values.
  Assumes it is included by bare name by the package and the design modules.
*/
// Notes on behaviour
// - Full state kept per queue; the flag shows only the write-selected queue.
// - Write select taken on strobe edge; flag shows new queue one cycle later.
// - Writes to a newly selected queue are refused until the second edge after.
// - Every full flag change happens on a rising clock edge.
// - Reads update a queue's full state even when not write-selected.
// - Full flag output released automatically when none of our queues is selected.
// - Full flag driven only when select bits 4..2 equal the device id.
// - Selections within this device keep driving, flag follows each queue.
// - Valid flag updates on the same edge that loads the output word.
// - Empty state kept per queue; only the read-selected queue drives validity.
// - After the last word, valid flag goes invalid on the next enabled read.
// - New read queue word and its flag appear two edges after selection.
// - Every valid flag change happens on a rising clock edge.
// - Writes mark a queue not-empty even when not read-selected.
// - Select buses are five bits: two pick a queue; three pick a device on the write bus only.
// - Full flag high when not full; valid flag low when word valid.
`ifndef MQF_CFG_SVH
`define MQF_CFG_SVH

`define MQF_DATA_W     36
`define MQF_NQ         4
`define MQF_QSEL_W     2
`define MQF_SEL_W      5
`define MQF_ID_W       3
`define MQF_ID_LSB     2
`define MQF_ID_MSB     4
`define MQF_QSEL_MSB   1
`define MQF_DEPTH      16
`define MQF_PTR_W      4
`define MQF_CNT_W      5
`define MQF_BUF_W      38
`define MQF_FLAG_RST   1'b1
`define MQF_MATCH_RST  1'b0
`define MQF_WORD_RST   36'h0_0000_0000
`define MQF_CNT_ONE    5'h01
`define MQF_CNT_ZERO   5'h00
`define MQF_PTR_ONE    4'h1
`define MQF_PTR_ZERO   4'h0
`define MQF_QSEL_ZERO  2'h0

`endif

//--- design/mqf_pkg.sv
/*
  Types shared by the multi-queue flag block.
  Assumes the constants header is on the include path.
*/
`include "mqf_cfg.svh"

package mqf_pkg;

  typedef logic [`MQF_DATA_W-1:0] mqf_word_t;
  typedef logic [`MQF_CNT_W-1:0]  mqf_cnt_t;
  typedef logic [`MQF_PTR_W-1:0]  mqf_ptr_t;
  typedef logic [`MQF_QSEL_W-1:0] mqf_qsel_t;

  // Write-port selection phase: settling blocks writes for one cycle.
  typedef enum logic [0:0] {
    MQF_WS_OPEN   = 1'b0,
    MQF_WS_SETTLE = 1'b1
  } mqf_wsel_t;

endpackage : mqf_pkg

//--- design/mqf_skid.sv
/*
  Two-entry buffer with valid and ready on both sides.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`include "mqf_cfg.svh"

module mqf_skid #(
  parameter int W = `MQF_BUF_W
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  // Filling side
  input  wire logic         i_valid,
  output logic              o_ready,
  input  wire logic [W-1:0] i_data,
  // Draining side
  output logic              o_valid,
  input  wire logic         i_ready,
  output logic [W-1:0]      o_data
);

  logic [W-1:0] mem_r [2];
  logic         wr_idx_r;
  logic         rd_idx_r;
  logic [1:0]   fill_r;
  logic         push;
  logic         pop;

  assign o_ready = (fill_r != 2'h2);
  assign o_valid = (fill_r != 2'h0);
  assign o_data  = mem_r[rd_idx_r];
  assign push    = i_valid & o_ready;
  assign pop     = o_valid & i_ready;

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_r[wr_idx_r] <= i_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wr_idx_r <= 1'b0;
      rd_idx_r <= 1'b0;
      fill_r   <= 2'h0;
    end else begin
      if (push) begin
        wr_idx_r <= ~wr_idx_r;
      end
      if (pop) begin
        rd_idx_r <= ~rd_idx_r;
      end
      case ({push, pop})
        2'b10:   fill_r <= fill_r + 2'h1;
        2'b01:   fill_r <= fill_r - 2'h1;
        default: fill_r <= fill_r;
      endcase
    end
  end

endmodule // mqf_skid

//--- design/mqf_top.sv
/*
  Multi-queue store with the active-queue full flag on the write port and the
  output-valid flag on the read port, four queues, first-word-fall-through output.
  Assumes both ports share one clock and all inputs are synchronous to it.
*/
`timescale 1ns/1ps
`include "mqf_cfg.svh"

module mqf_top (
  // Clock and reset
  input  wire logic                   I_CLK,
  input  wire logic                   I_SYS_RST,
  // Write port
  input  wire logic [`MQF_SEL_W-1:0]  I_WRITE_QUEUE_SELECT_BUS,
  input  wire logic                   I_WRITE_SELECT_STROBE,
  input  wire logic                   I_WRITE_ENABLE_N,
  input  wire logic [`MQF_DATA_W-1:0] I_WRITE_DATA,
  output logic                        O_WRITE_READY,
  // Device identity straps
  input  wire logic                   I_DEVICE_ID_BIT0,
  input  wire logic                   I_DEVICE_ID_BIT1,
  input  wire logic                   I_DEVICE_ID_BIT2,
  // Shared full flag, three-state pin
  output logic                        O_ACTIVE_QUEUE_FULL_FLAG_N,
  output logic                        O_ACTIVE_QUEUE_FULL_FLAG_OE,
  // Read port
  input  wire logic [`MQF_SEL_W-1:0]  I_READ_QUEUE_SELECT_BUS,
  input  wire logic                   I_READ_SELECT_STROBE,
  input  wire logic                   I_READ_ENABLE_N,
  output logic [`MQF_DATA_W-1:0]      O_READ_DATA_OUT,
  output logic                        O_OUTPUT_VALID_FLAG_N
);

  // ----------------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------------
  mqf_pkg::mqf_word_t mem_r [`MQF_NQ][`MQF_DEPTH];
  mqf_pkg::mqf_ptr_t  wptr_r [`MQF_NQ];
  mqf_pkg::mqf_ptr_t  rptr_r [`MQF_NQ];
  mqf_pkg::mqf_cnt_t  cnt_r [`MQF_NQ];
  mqf_pkg::mqf_cnt_t  cnt_nxt [`MQF_NQ];

  mqf_pkg::mqf_qsel_t wr_q_r;
  logic               wr_match_r;
  mqf_pkg::mqf_wsel_t ws_r;
  logic               ff_n_r;
  logic [`MQF_ID_W-1:0] dev_id;
  logic               wr_take;
  logic               buf_in_ready;
  logic               buf_valid;
  logic               drain;
  logic [`MQF_BUF_W-1:0] buf_data;
  mqf_pkg::mqf_qsel_t drain_q;
  logic               act_full;

  mqf_pkg::mqf_qsel_t rd_sel_r;
  mqf_pkg::mqf_qsel_t rd_act_r;
  logic               rd_stb_d_r;
  logic               rd_sw_r;
  logic               ov_n_r;
  mqf_pkg::mqf_word_t rd_data_r;
  logic               load;
  logic               pop;
  logic [`MQF_NQ-1:0] push_v;
  logic [`MQF_NQ-1:0] pop_v;

  function automatic logic q_full(input mqf_pkg::mqf_cnt_t c);
    q_full = (c == `MQF_CNT_W'(`MQF_DEPTH));
  endfunction

  function automatic logic q_empty(input mqf_pkg::mqf_cnt_t c);
    q_empty = (c == `MQF_CNT_ZERO);
  endfunction

  // ----------------------------------------------------------------------------
  // Write-port queue selection
  // ----------------------------------------------------------------------------
  assign dev_id = {I_DEVICE_ID_BIT2, I_DEVICE_ID_BIT1, I_DEVICE_ID_BIT0};

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      wr_q_r     <= `MQF_QSEL_ZERO;
      wr_match_r <= `MQF_MATCH_RST;
      ws_r       <= mqf_pkg::MQF_WS_OPEN;
    end else if (I_WRITE_SELECT_STROBE) begin
      wr_q_r     <= I_WRITE_QUEUE_SELECT_BUS[`MQF_QSEL_MSB:0];
      // A match keeps this device on the shared flag across its own queues.
      wr_match_r <= (I_WRITE_QUEUE_SELECT_BUS[`MQF_ID_MSB:`MQF_ID_LSB] == dev_id);
      ws_r       <= mqf_pkg::MQF_WS_SETTLE;
    end else begin
      ws_r       <= mqf_pkg::MQF_WS_OPEN;
    end
  end

  // ----------------------------------------------------------------------------
  // Write acceptance and buffer towards the queues
  // ----------------------------------------------------------------------------
  // A write is taken only outside the settle cycle and only for our own device.
  assign wr_take = ~I_WRITE_ENABLE_N & (ws_r == mqf_pkg::MQF_WS_OPEN) & wr_match_r
                   & buf_in_ready;
  assign O_WRITE_READY = buf_in_ready;

  mqf_skid #(
    .W (`MQF_BUF_W)
  ) u_wbuf (
    .i_clk   (I_CLK),
    .i_rst   (I_SYS_RST),
    .i_valid (wr_take),
    .o_ready (buf_in_ready),
    .i_data  ({wr_q_r, I_WRITE_DATA}),
    .o_valid (buf_valid),
    .i_ready (drain),
    .o_data  (buf_data)
  );

  assign drain_q = buf_data[`MQF_BUF_W-1:`MQF_DATA_W];
  // A full queue holds the word in the buffer, which back-pressures the port.
  assign drain   = buf_valid & ~q_full(cnt_r[drain_q]);

  // ----------------------------------------------------------------------------
  // Per-queue storage and occupancy
  // ----------------------------------------------------------------------------
  always_comb begin
    for (int q = 0; q < `MQF_NQ; q++) begin
      push_v[q] = drain & (drain_q == `MQF_QSEL_W'(q));
      pop_v[q]  = pop & (rd_act_r == `MQF_QSEL_W'(q));
      cnt_nxt[q] = cnt_r[q];
      if (push_v[q] & ~pop_v[q]) begin
        cnt_nxt[q] = cnt_r[q] + `MQF_CNT_ONE;
      end else if (pop_v[q] & ~push_v[q]) begin
        cnt_nxt[q] = cnt_r[q] - `MQF_CNT_ONE;
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      for (int q = 0; q < `MQF_NQ; q++) begin
        cnt_r[q]  <= `MQF_CNT_ZERO;
        wptr_r[q] <= `MQF_PTR_ZERO;
        rptr_r[q] <= `MQF_PTR_ZERO;
      end
    end else begin
      for (int q = 0; q < `MQF_NQ; q++) begin
        cnt_r[q] <= cnt_nxt[q];
        if (push_v[q]) begin
          wptr_r[q] <= wptr_r[q] + `MQF_PTR_ONE;
        end
        if (pop_v[q]) begin
          rptr_r[q] <= rptr_r[q] + `MQF_PTR_ONE;
        end
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (drain) begin
      mem_r[drain_q][wptr_r[drain_q]] <= buf_data[`MQF_DATA_W-1:0];
    end
  end

  // ----------------------------------------------------------------------------
  // Active-queue full flag
  // ----------------------------------------------------------------------------
  assign act_full = q_full(cnt_r[wr_q_r]);

  // The selected queue updates at the strobe edge, so the flag follows one edge later.
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      ff_n_r <= `MQF_FLAG_RST;
    end else begin
      ff_n_r <= ~act_full;
    end
  end

  assign O_ACTIVE_QUEUE_FULL_FLAG_N  = ff_n_r;
  assign O_ACTIVE_QUEUE_FULL_FLAG_OE = wr_match_r;

  // ----------------------------------------------------------------------------
  // Read-port selection pipeline
  // ----------------------------------------------------------------------------
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      rd_sel_r   <= `MQF_QSEL_ZERO;
      rd_act_r   <= `MQF_QSEL_ZERO;
      rd_stb_d_r <= 1'b0;
      rd_sw_r    <= 1'b0;
    end else begin
      if (I_READ_SELECT_STROBE) begin
        rd_sel_r <= I_READ_QUEUE_SELECT_BUS[`MQF_QSEL_MSB:0];
      end
      // Two stages so the old queue keeps feeding the output meanwhile.
      rd_stb_d_r <= I_READ_SELECT_STROBE;
      rd_act_r   <= rd_sel_r;
      rd_sw_r    <= rd_stb_d_r;
    end
  end

  // ----------------------------------------------------------------------------
  // Output register and valid flag
  // ----------------------------------------------------------------------------
  // The register refills when empty, when read, or to show a newly switched queue.
  assign load = ov_n_r | ~I_READ_ENABLE_N | rd_sw_r;
  assign pop  = load & ~q_empty(cnt_r[rd_act_r]);

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      ov_n_r    <= `MQF_FLAG_RST;
      rd_data_r <= `MQF_WORD_RST;
    end else begin
      if (pop) begin
        rd_data_r <= mem_r[rd_act_r][rptr_r[rd_act_r]];
      end
      if (load) begin
        ov_n_r <= ~pop;
      end
    end
  end

  assign O_READ_DATA_OUT       = rd_data_r;
  assign O_OUTPUT_VALID_FLAG_N = ov_n_r;

  // ----------------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST);

  a_ff_new_queue: assert property (
    I_WRITE_SELECT_STROBE |=> ##1
      (O_ACTIVE_QUEUE_FULL_FLAG_N == $past(~act_full)))
    else $error("full flag did not follow the new write queue");

  a_wr_settle_block: assert property (
    I_WRITE_SELECT_STROBE |=> !wr_take)
    else $error("write taken in the cycle after a selection");

  a_wr_reopen: assert property (
    I_WRITE_SELECT_STROBE ##1 !I_WRITE_SELECT_STROBE |=> (ws_r == mqf_pkg::MQF_WS_OPEN))
    else $error("write window not open on second edge after selection");

  a_oe_id_match: assert property (
    I_WRITE_SELECT_STROBE |=> (O_ACTIVE_QUEUE_FULL_FLAG_OE ==
      ($past(I_WRITE_QUEUE_SELECT_BUS[`MQF_ID_MSB:`MQF_ID_LSB]) == $past(dev_id))))
    else $error("full flag drive does not match device id");

  a_ff_full_low: assert property (
    (act_full && !I_WRITE_SELECT_STROBE) |=> !O_ACTIVE_QUEUE_FULL_FLAG_N)
    else $error("full flag high while active queue full");

  a_ov_new_queue: assert property (
    I_READ_SELECT_STROBE ##1 !I_READ_SELECT_STROBE |=>
      (rd_sw_r && rd_act_r == $past(rd_sel_r)) ##1
      (O_OUTPUT_VALID_FLAG_N == $past(q_empty(cnt_r[rd_act_r]))))
    else $error("new read queue not presented two edges after selection");

  a_ov_last_word: assert property (
    (!O_OUTPUT_VALID_FLAG_N && !I_READ_ENABLE_N && q_empty(cnt_r[rd_act_r]))
      |=> O_OUTPUT_VALID_FLAG_N)
    else $error("valid flag stayed low after last word was read");

  a_ov_hold: assert property (
    (!O_OUTPUT_VALID_FLAG_N && I_READ_ENABLE_N && !rd_sw_r) |=>
      ($stable(O_OUTPUT_VALID_FLAG_N) && $stable(O_READ_DATA_OUT)))
    else $error("output word changed without a read");

  a_push_not_empty: assert property (
    (|push_v) |=> !q_empty(cnt_r[$past(drain_q)]))
    else $error("written queue still empty");

  a_pop_not_full: assert property (
    (|pop_v) |=> !q_full(cnt_r[$past(rd_act_r)]))
    else $error("read queue still full");

  a_reset_flags: assert property (
    $past(I_SYS_RST) |-> (O_ACTIVE_QUEUE_FULL_FLAG_N && O_OUTPUT_VALID_FLAG_N))
    else $error("flags wrong after reset");

  c_full_seen: cover property (!O_ACTIVE_QUEUE_FULL_FLAG_N && O_ACTIVE_QUEUE_FULL_FLAG_OE);
  c_write_after_switch: cover property (I_WRITE_SELECT_STROBE ##2 wr_take);
  c_read_switch_valid: cover property (rd_sw_r ##1 !O_OUTPUT_VALID_FLAG_N);
  c_stall_full_buffer: cover property (!buf_in_ready);

endmodule // mqf_top

//--- verif/mqf_ctl_mdl.sv
/*
  Model of the system controller at the far side: resolves the shared full-flag wire
  and paces reads, promptly or with random stalls.
  Assumes one clock shared with the flag block.
*/
`timescale 1ns/1ps

module mqf_ctl_mdl (
  // Clock
  input  wire logic i_clk,
  // Full flag pin of the block
  input  wire logic i_flag_n,
  input  wire logic i_flag_oe,
  // Pacing controls
  input  wire logic i_rd_go,
  input  wire logic i_slow,
  // Controller view
  output logic      o_flag_wire,
  output logic      o_read_enable_n,
  output logic      o_may_write
);
  logic last_r;

  initial last_r = 1'b1;
  initial o_read_enable_n = 1'b1;

  always @(posedge i_clk) begin
    if (i_flag_oe) begin
      last_r <= i_flag_n;
    end
  end

  // A released wire has no pull-up, so it shows the inverse of its last level.
  assign o_flag_wire = i_flag_oe ? i_flag_n : ~last_r;
  assign o_may_write = i_flag_oe & o_flag_wire;

  always @(posedge i_clk) begin
    o_read_enable_n <= ~(i_rd_go & (~i_slow | ($urandom_range(1, 0) == 1)));
  end
endmodule // mqf_ctl_mdl

//--- verif/tb.sv
/*
  Self-checking bench of the multi-queue flag block with a reference queue per queue.
  Assumes the design files and the controller model are compiled first.
*/
`timescale 1ns/1ps
`include "mqf_cfg.svh"

module tb;
  localparam logic [2:0] ID = 3'h5;
  logic                   clk, rst, wstb, wen_n, rstb, rd_go, slow, chk_empty;
  logic [`MQF_SEL_W-1:0]  wsel, rsel;
  logic [`MQF_DATA_W-1:0] wdat, rdat;
  logic                   wrdy, ff_n, ff_oe, ov_n, ren_n, fwire, may;
  logic [`MQF_DATA_W-1:0] mq[4][$];
  logic [1:0]             wq, rq;
  int                     n_mismatch, n_compared;

  mqf_top u_mqf_top (
    .I_CLK(clk), .I_SYS_RST(rst), .I_WRITE_QUEUE_SELECT_BUS(wsel),
    .I_WRITE_SELECT_STROBE(wstb), .I_WRITE_ENABLE_N(wen_n), .I_WRITE_DATA(wdat),
    .O_WRITE_READY(wrdy), .I_DEVICE_ID_BIT0(ID[0]), .I_DEVICE_ID_BIT1(ID[1]),
    .I_DEVICE_ID_BIT2(ID[2]), .O_ACTIVE_QUEUE_FULL_FLAG_N(ff_n),
    .O_ACTIVE_QUEUE_FULL_FLAG_OE(ff_oe), .I_READ_QUEUE_SELECT_BUS(rsel),
    .I_READ_SELECT_STROBE(rstb), .I_READ_ENABLE_N(ren_n), .O_READ_DATA_OUT(rdat),
    .O_OUTPUT_VALID_FLAG_N(ov_n));

  mqf_ctl_mdl u_mqf_ctl_mdl (
    .i_clk(clk), .i_flag_n(ff_n), .i_flag_oe(ff_oe), .i_rd_go(rd_go), .i_slow(slow),
    .o_flag_wire(fwire), .o_read_enable_n(ren_n), .o_may_write(may));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic chk(input logic [`MQF_DATA_W-1:0] seen, input logic [`MQF_DATA_W-1:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic give_up;
    n_mismatch++;
    final_report();
  endtask

  // Consumed words are compared against the reference queue of the read queue.
  always @(posedge clk) begin
    if (!rst) begin
      if (chk_empty) begin
        chk(ov_n, 1'b1);
        chk_empty = 1'b0;
      end
      if (ov_n === 1'b0 && ren_n === 1'b0) begin
        if (mq[rq].size() == 0) begin
          chk(1'b1, 1'b0);
        end else begin
          chk(rdat, mq[rq].pop_front());
          chk_empty = (mq[rq].size() == 0);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Port tasks
  // ----------------------------------------------------------------
  task automatic sel_w(input logic [`MQF_SEL_W-1:0] a);
    logic old;
    repeat (4) @(posedge clk);
    old = ff_n;
    wstb <= 1'b1;
    wsel <= a;
    @(posedge clk);
    wstb  <= 1'b0;
    wen_n <= 1'b0;
    wdat  <= {4'h0, $urandom()};
    @(negedge clk);
    chk(ff_oe, a[4:2] == ID);
    if (a[4:2] == ID) chk(ff_n, old);
    @(posedge clk);
    wen_n <= 1'b1;
    if (a[4:2] == ID) begin
      wq = a[1:0];
      @(negedge clk);
      chk(ff_n, mq[wq].size() != `MQF_DEPTH);
    end
  endtask

  task automatic wr(input logic [`MQF_DATA_W-1:0] d);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (!(wrdy === 1'b1 && may === 1'b1) && n < 50);
    if (n >= 50) give_up();
    @(posedge clk);
    wen_n <= 1'b0;
    wdat  <= d;
    mq[wq].push_back(d);
    @(posedge clk);
    wen_n <= 1'b1;
  endtask

  task automatic sel_r(input logic [1:0] q);
    logic old;
    @(posedge clk);
    rd_go <= 1'b0;
    repeat (2) @(posedge clk);
    rstb <= 1'b1;
    rsel <= {3'h0, q};
    @(posedge clk);
    rstb <= 1'b0;
    old = ov_n;
    rq = q;
    @(negedge clk);
    chk(ov_n, old);
    @(posedge clk);
    @(negedge clk);
    chk(ov_n, old);
    @(posedge clk);
    @(negedge clk);
    chk(ov_n, mq[q].size() == 0);
    chk(rdat, mq[q][0]);
    @(posedge clk);
    rd_go <= 1'b1;
  endtask

  task automatic drain(input logic [1:0] q);
    int n;
    n = 0;
    while (mq[q].size() != 0 && n < 500) begin
      @(negedge clk);
      n++;
    end
    if (n >= 500) give_up();
    repeat (3) @(posedge clk);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int n;
    {wstb, rstb, rd_go, slow, chk_empty} = '0;
    {wen_n, rst} = 2'h3;
    {wsel, rsel, wdat, wq, rq} = '0;
    n_mismatch = 0;
    n_compared = 0;
    void'($urandom(46836));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk(ff_n, 1'b1);
    chk(ff_oe, 1'b0);
    chk(ov_n, 1'b1);
    chk(wrdy, 1'b1);
    for (int c = 0; c < 8; c++) sel_w({c[2:0], 2'h3});
    sel_w({ID, 2'h1});
    repeat (`MQF_DEPTH) wr({4'($urandom()), $urandom()});
    repeat (6) @(posedge clk);
    @(negedge clk);
    chk(ff_n, 1'b0);
    sel_w({ID, 2'h2});
    repeat (3) wr({4'($urandom()), $urandom()});
    sel_w({ID, 2'h1});
    slow = 1'b1;
    sel_r(2'h1);
    n = 0;
    while (fwire !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk(fwire, 1'b1);
    drain(2'h1);
    slow = 1'b0;
    sel_r(2'h2);
    drain(2'h2);
    final_report();
  end

  initial begin
    repeat (20000) @(posedge clk);
    give_up();
  end
endmodule // tb
